// ### rtl/usb_endpoint_config.sv
// Endpoint configuration registers with an AXI4-Lite slave
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module usb_endpoint_config
	import usb_endpoint_config_pkg::*;
(
	input  wire logic                                       sys_clk,
	input  wire logic                                       rst_n,
	input  wire logic [usb_endpoint_config_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
	input  wire logic                                       s_axi_awvalid,
	output logic                                            s_axi_awready,
	input  wire logic [usb_endpoint_config_pkg::DATA_WIDTH-1:0] s_axi_wdata,
	input  wire logic [3:0]                                 s_axi_wstrb,
	input  wire logic                                       s_axi_wvalid,
	output logic                                            s_axi_wready,
	output logic [1:0]                                      s_axi_bresp,
	output logic                                            s_axi_bvalid,
	input  wire logic                                       s_axi_bready,
	input  wire logic [usb_endpoint_config_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
	input  wire logic                                       s_axi_arvalid,
	output logic                                            s_axi_arready,
	output logic [usb_endpoint_config_pkg::DATA_WIDTH-1:0]  s_axi_rdata,
	output logic [1:0]                                      s_axi_rresp,
	output logic                                            s_axi_rvalid,
	input  wire logic                                       s_axi_rready,
	input  wire logic                                       token_valid,
	input  wire logic [3:0]                                 token_endpoint_index,
	input  wire logic                                       token_direction_in,
	output logic                                            token_accept,
	output usb_endpoint_config_pkg::endpoint_settings_type  endpoint_settings,
	output logic [9:0]                                      max_packet_bytes,
	output usb_endpoint_config_pkg::data_link_type          data_link,
	output logic                                            always_toggle,
	output logic                                            ping_flow_control
);
	import usb_endpoint_config_pkg::*;

	logic [7:0]            max_high;
	logic [7:0]            max_low;
	logic [7:0]            configuration;
	logic [7:0]            join_second;
	logic [7:0]            accept_count;
	logic                  aw_held;
	logic [INDEX_WIDTH-1:0] aw_index;
	logic                  w_held;
	logic [7:0]            w_byte;
	logic                  w_lane;
	logic [7:0]            next_max_high;
	logic [7:0]            next_max_low;
	logic [7:0]            next_configuration;
	logic [7:0]            next_join_second;
	logic [7:0]            next_accept_count;
	logic                  next_aw_held;
	logic [INDEX_WIDTH-1:0] next_aw_index;
	logic                  next_w_held;
	logic [7:0]            next_w_byte;
	logic                  next_w_lane;
	logic                  next_bvalid;
	logic [1:0]            next_bresp;
	logic                  next_rvalid;
	logic [1:0]            next_rresp;
	logic [DATA_WIDTH-1:0] next_rdata;
	logic                  write_fire;
	logic                  read_fire;
	logic [INDEX_WIDTH-1:0] ar_index;
	logic [7:0]            read_byte;
	logic                  read_hit;
	logic [3:0]            join_pick;

	// Settings, size and link outputs come straight from register bits; the low three size bits are tied to zero
	assign endpoint_settings.direction_select = configuration[BIT_DIRECTION];
	assign endpoint_settings.interrupt_behaviour_select =
		configuration[BIT_INTERRUPT_MODE];
	assign endpoint_settings.endpoint_on = configuration[BIT_ENDPOINT_ON];
	assign endpoint_settings.endpoint_index = configuration[BIT_INDEX_TOP:0];
	assign max_packet_bytes = {max_high[BIT_SIZE_HIGH_TOP:0],
		max_low[BIT_SIZE_LOW_TOP:BIT_SIZE_LOW_BOTTOM], 3'h0};
	assign data_link.link_dma_channel_one = join_second[JOIN_DMA_ONE];
	assign data_link.link_dma_channel_zero = join_second[JOIN_DMA_ZERO];
	assign data_link.link_processor_read = join_second[JOIN_READ];
	assign data_link.link_processor_write = join_second[JOIN_WRITE];
	// Toggle every transaction only for IN with mode set
	assign always_toggle = configuration[BIT_DIRECTION]
		& configuration[BIT_INTERRUPT_MODE];
	// PING only for bulk OUT
	assign ping_flow_control = ~configuration[BIT_DIRECTION]
		& ~configuration[BIT_INTERRUPT_MODE];
	// Disabled endpoint answers nothing on the bus
	assign token_accept = token_valid & configuration[BIT_ENDPOINT_ON]
		& (token_endpoint_index == configuration[BIT_INDEX_TOP:0])
		& (token_direction_in == configuration[BIT_DIRECTION]);

	assign s_axi_awready = ~aw_held;
	assign s_axi_wready = ~w_held;
	assign s_axi_arready = ~s_axi_rvalid;
	assign write_fire = aw_held & w_held & ~s_axi_bvalid;
	assign read_fire = s_axi_arvalid & ~s_axi_rvalid;
	assign ar_index = s_axi_araddr[ADDR_WIDTH-1:2];

	// Highest written join bit wins, so a burst of ones cannot double-book
	always_comb
	begin
		join_pick = 4'h0;
		if (w_byte[JOIN_DMA_ONE])
			join_pick[JOIN_DMA_ONE] = 1'b1;
		else if (w_byte[JOIN_DMA_ZERO])
			join_pick[JOIN_DMA_ZERO] = 1'b1;
		else if (w_byte[JOIN_READ])
			join_pick[JOIN_READ] = 1'b1;
		else if (w_byte[JOIN_WRITE])
			join_pick[JOIN_WRITE] = 1'b1;
	end

	always_comb
	begin
		read_hit = 1'b1;
		unique case (ar_index)
			INDEX_JOIN_SECOND:     read_byte = join_second;
			INDEX_MAX_PACKET_HIGH: read_byte = max_high;
			INDEX_MAX_PACKET_LOW:  read_byte = max_low;
			INDEX_CONFIGURATION:   read_byte = configuration;
			INDEX_ACCEPT_STATUS:   read_byte = accept_count;
			default:
			begin
				read_byte = RESET_VALUE;
				read_hit = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		next_max_high = max_high;
		next_max_low = max_low;
		next_configuration = configuration;
		next_join_second = join_second;
		next_accept_count = accept_count + {7'h00, token_accept};
		next_aw_held = aw_held;
		next_aw_index = aw_index;
		next_w_held = w_held;
		next_w_byte = w_byte;
		next_w_lane = w_lane;
		next_bvalid = s_axi_bvalid & ~s_axi_bready;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid & ~s_axi_rready;
		next_rresp = s_axi_rresp;
		next_rdata = s_axi_rdata;
		if (s_axi_awvalid & ~aw_held)
		begin
			next_aw_held = 1'b1;
			next_aw_index = s_axi_awaddr[ADDR_WIDTH-1:2];
		end
		if (s_axi_wvalid & ~w_held)
		begin
			next_w_held = 1'b1;
			next_w_byte = s_axi_wdata[7:0];
			next_w_lane = s_axi_wstrb[0];
		end
		if (write_fire)
		begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			// Masks drop writes to reserved bits
			unique case (aw_index)
				INDEX_JOIN_SECOND:
					if (w_lane)
						next_join_second = {4'h0, join_pick} & MASK_JOIN;
				INDEX_MAX_PACKET_HIGH:
					if (w_lane)
						next_max_high = w_byte & MASK_MAX_PACKET_HIGH;
				INDEX_MAX_PACKET_LOW:
					if (w_lane)
						next_max_low = w_byte & MASK_MAX_PACKET_LOW;
				INDEX_CONFIGURATION:
					if (w_lane)
						next_configuration = w_byte & MASK_CONFIGURATION;
				INDEX_ACCEPT_STATUS:
					next_bresp = RESP_OKAY;
				default:
					next_bresp = RESP_SLVERR;
			endcase
		end
		if (read_fire)
		begin
			next_rvalid = 1'b1;
			next_rdata = {24'h000000, read_byte};
			next_rresp = read_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			max_high <= RESET_VALUE;
			max_low <= RESET_VALUE;
			configuration <= RESET_VALUE;
			join_second <= RESET_VALUE;
			accept_count <= RESET_VALUE;
			aw_held <= 1'b0;
			aw_index <= '0;
			w_held <= 1'b0;
			w_byte <= RESET_VALUE;
			w_lane <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= '0;
		end
		else
		begin
			max_high <= next_max_high;
			max_low <= next_max_low;
			configuration <= next_configuration;
			join_second <= next_join_second;
			accept_count <= next_accept_count;
			aw_held <= next_aw_held;
			aw_index <= next_aw_index;
			w_held <= next_w_held;
			w_byte <= next_w_byte;
			w_lane <= next_w_lane;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
		end
	end
endmodule
`default_nettype wire

// ### rtl/usb_endpoint_config_pkg.sv
// Constants and carrier types for the endpoint configuration block
package usb_endpoint_config_pkg;
	localparam int ADDR_WIDTH = 11;
	localparam int DATA_WIDTH = 32;
	localparam int INDEX_WIDTH = 9;

	// Register indices; byte address is four times the index
	localparam logic [INDEX_WIDTH-1:0] INDEX_JOIN_SECOND = 9'h145;
	localparam logic [INDEX_WIDTH-1:0] INDEX_MAX_PACKET_HIGH = 9'h150;
	localparam logic [INDEX_WIDTH-1:0] INDEX_MAX_PACKET_LOW = 9'h151;
	localparam logic [INDEX_WIDTH-1:0] INDEX_CONFIGURATION = 9'h152;
	localparam logic [INDEX_WIDTH-1:0] INDEX_ACCEPT_STATUS = 9'h15F;

	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam logic [7:0] MASK_MAX_PACKET_HIGH = 8'h03;
	localparam logic [7:0] MASK_MAX_PACKET_LOW = 8'hF8;
	localparam logic [7:0] MASK_CONFIGURATION = 8'hEF;
	localparam logic [7:0] MASK_JOIN = 8'h0F;

	// Field positions
	localparam int BIT_DIRECTION = 7;
	localparam int BIT_INTERRUPT_MODE = 6;
	localparam int BIT_ENDPOINT_ON = 5;
	localparam int BIT_INDEX_TOP = 3;
	localparam int BIT_SIZE_LOW_TOP = 7;
	localparam int BIT_SIZE_LOW_BOTTOM = 3;
	localparam int BIT_SIZE_HIGH_TOP = 1;
	localparam int JOIN_DMA_ONE = 3;
	localparam int JOIN_DMA_ZERO = 2;
	localparam int JOIN_READ = 1;
	localparam int JOIN_WRITE = 0;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic       direction_select;
		logic       interrupt_behaviour_select;
		logic       endpoint_on;
		logic [3:0] endpoint_index;
	} endpoint_settings_type;

	typedef struct packed {
		logic link_dma_channel_one;
		logic link_dma_channel_zero;
		logic link_processor_read;
		logic link_processor_write;
	} data_link_type;
endpackage

// ### sim/usb_token_host.sv
// Host model sending random tokens at the endpoint
`timescale 1ns/1ns
`default_nettype none
module usb_token_host (
	input  wire logic       sys_clk,
	input  wire logic       run,
	output logic            token_valid,
	output logic [3:0]      token_endpoint_index,
	output logic            token_direction_in
);
	int s = 32'h4ea3159c;
	initial {token_valid, token_endpoint_index, token_direction_in} = 6'h00;
	always @(posedge sys_clk)
	begin
		token_valid <= run & 1'($random(s));
		// Idle lines flip so a stale token never looks fresh
		token_endpoint_index <= run ? 4'($random(s)) : ~token_endpoint_index;
		token_direction_in <= run ? 1'($random(s)) : ~token_direction_in;
	end
endmodule
`default_nettype wire

// ### sim/usb_endpoint_config_sva.sv
// Checker for the endpoint configuration outputs
`timescale 1ns/1ns
`default_nettype none
module usb_endpoint_config_sva (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        token_valid,
	input wire logic [3:0]  token_endpoint_index,
	input wire logic        token_direction_in,
	input wire logic        token_accept,
	input wire usb_endpoint_config_pkg::endpoint_settings_type endpoint_settings,
	input wire logic [9:0]  max_packet_bytes,
	input wire usb_endpoint_config_pkg::data_link_type data_link,
	input wire logic        always_toggle,
	input wire logic        ping_flow_control
);
	import usb_endpoint_config_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	join_one_hot_a: assert property ($onehot0(data_link))
		else $error("join bits not one-hot");
	size_granule_a: assert property (max_packet_bytes[2:0] == 3'h0)
		else $error("size low bits set");
	write_only_a: assert property ($changed({max_packet_bytes,
		endpoint_settings, data_link}) |-> s_axi_bvalid)
		else $error("setting moved without a write");
	in_toggle_a: assert property (always_toggle == (
		endpoint_settings.direction_select
		&& endpoint_settings.interrupt_behaviour_select))
		else $error("toggle mode wrong");
	out_ping_a: assert property (ping_flow_control == (
		!endpoint_settings.direction_select
		&& !endpoint_settings.interrupt_behaviour_select))
		else $error("ping mode wrong");
	off_ignore_a: assert property (!endpoint_settings.endpoint_on
		|-> !token_accept) else $error("disabled endpoint answered");
	accept_match_a: assert property (token_accept == (token_valid
		&& endpoint_settings.endpoint_on
		&& token_endpoint_index == endpoint_settings.endpoint_index
		&& token_direction_in == endpoint_settings.direction_select))
		else $error("token accept wrong");
	rdata_zero_a: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	cover property (token_accept);
	cover property (data_link.link_dma_channel_one);
	cover property (always_toggle);
endmodule
bind usb_endpoint_config usb_endpoint_config_sva u_sva (.sys_clk, .rst_n,
	.s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata, .token_valid,
	.token_endpoint_index, .token_direction_in, .token_accept,
	.endpoint_settings, .max_packet_bytes, .data_link, .always_toggle,
	.ping_flow_control);
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the endpoint configuration block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import usb_endpoint_config_pkg::*;
	logic sys_clk = 0, rst_n = 0, run = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [10:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, token_valid, token_direction_in, token_accept;
	logic always_toggle, ping_flow_control;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] token_endpoint_index;
	logic [9:0] max_packet_bytes;
	endpoint_settings_type endpoint_settings;
	data_link_type data_link;
	logic [7:0] cfg = 0, acc_exp = 0;
	logic [3:0] s_axi_wstrb = 4'h1;
	int seed = 32'h4ea3159c, miscompares = 0, n_checks = 0, cyc = 0;
	usb_endpoint_config DUT (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .token_valid,
		.token_endpoint_index, .token_direction_in, .token_accept,
		.endpoint_settings, .max_packet_bytes, .data_link, .always_toggle,
		.ping_flow_control);
	usb_token_host host (.sys_clk, .run, .token_valid, .token_endpoint_index,
		.token_direction_in);
	initial forever #50 sys_clk = ~sys_clk;
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic bad(input string m);
		miscompares++;
		$display("ERROR %0t %s", $time, m);
	endtask
	task automatic chk_val(input logic [31:0] g, e);
		n_checks++;
		if (g !== e) bad("value mismatch");
	endtask
	task automatic chk_resp(input logic [1:0] g, e);
		n_checks++;
		if (g !== e) bad("response mismatch");
	endtask
	task automatic wr(input logic [8:0] i, input logic [7:0] v,
		output logic [1:0] r);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
		// Idle edge so a following call never re-raises a line in this step
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [8:0] i, output logic [31:0] v,
		output logic [1:0] r);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge sys_clk);
	endtask
	task automatic wcheck(input logic [8:0] i, input logic [7:0] v, e);
		logic [31:0] q;
		logic [1:0] r;
		wr(i, v, r);
		chk_resp(r, RESP_OKAY);
		rd(i, q, r);
		chk_val(q, {24'h000000, e});
		chk_resp(r, RESP_OKAY);
	endtask
	function automatic logic [7:0] join_exp(input logic [7:0] v);
		for (int b = 3; b >= 0; b--)
			if (v[b]) return 8'h01 << b;
		return 8'h00;
	endfunction
	always @(posedge sys_clk)
		if (++cyc == 5000)
		begin
			bad("timeout");
			tally_and_finish;
		end
	function automatic logic accept_exp();
		return token_valid & cfg[5] & (cfg[7] == token_direction_in)
			& (token_endpoint_index == cfg[3:0]);
	endfunction
	// Checked from reset on, so a stray accept between tests is caught
	always @(negedge sys_clk)
		if (rst_n)
		begin
			chk_val(token_accept, accept_exp());
			acc_exp <= acc_exp + 8'(accept_exp());
		end
	initial
	begin
		logic [31:0] q;
		logic [1:0] r;
		logic [9:0] m;
		logic [7:0] d;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'h1;
		for (int k = 0; k < 3; k++)
		begin
			rd(INDEX_MAX_PACKET_HIGH + 9'(k), q, r);
			chk_val(q, 32'h00000000);
		end
		chk_val(ping_flow_control, 32'h00000001);
		chk_val(data_link, 32'h00000000);
		$display("reset test done");
		for (int k = 0; k < 8; k++)
		begin
			// Random sizes stay within the interrupt limit
			m = k == 0 ? 10'h200 : k == 1 ? 10'h040
				: {1'h0, 9'($random(seed))};
			d = 8'($random(seed));
			wcheck(INDEX_MAX_PACKET_HIGH, {d[7:2], m[9:8]},
				{6'h00, m[9:8]});
			wcheck(INDEX_MAX_PACKET_LOW, {m[7:3], d[2:0]},
				{m[7:3], 3'h0});
			chk_val(max_packet_bytes, {m[9:3], 3'h0});
		end
		$display("size test done");
		for (int k = 0; k < 6; k++)
		begin
			d = 8'($random(seed));
			// Nonzero index, enable on for the first four passes only
			cfg = {k[1:0], !k[2], d[4],
				d[3:0] == 0 ? 4'h1 : d[3:0]};
			wcheck(INDEX_CONFIGURATION, cfg,
				cfg & MASK_CONFIGURATION);
			chk_val(always_toggle, cfg[7] & cfg[6]);
			chk_val(ping_flow_control, !cfg[7] & !cfg[6]);
			chk_val(endpoint_settings, {cfg[7:5], cfg[3:0]});
			run <= 1'h1;
			repeat (40) @(posedge sys_clk);
			run <= 1'h0;
			@(posedge sys_clk);
		end
		$display("config test done");
		for (int k = 0; k < 16; k++)
		begin
			d = 8'(k) | 8'hF0 & 8'($random(seed));
			wcheck(INDEX_JOIN_SECOND, d, join_exp(d));
			chk_val(data_link, join_exp(d));
		end
		$display("join test done");
		wr(9'h146, 8'hFF, r);
		chk_resp(r, RESP_SLVERR);
		rd(9'h146, q, r);
		chk_val(q, 32'h00000000);
		chk_resp(r, RESP_SLVERR);
		// Strobe off: the low lane must not be written
		s_axi_wstrb <= 4'h0;
		wr(INDEX_CONFIGURATION, 8'hFF, r);
		s_axi_wstrb <= 4'h1;
		chk_resp(r, RESP_OKAY);
		rd(INDEX_CONFIGURATION, q, r);
		chk_val(q, {24'h000000, cfg & MASK_CONFIGURATION});
		chk_resp(r, RESP_OKAY);
		$display("unmapped test done");
		// Status counts accepted tokens; a write to it changes nothing
		wr(INDEX_ACCEPT_STATUS, 8'hFF, r);
		chk_resp(r, RESP_OKAY);
		rd(INDEX_ACCEPT_STATUS, q, r);
		chk_val(q, {24'h000000, acc_exp});
		chk_resp(r, RESP_OKAY);
		$display("accept count test done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
